// *** src/dpz_pd_zq_ctrl.sv ***
// Functional notes
// - Enter power-down on CKE low with NOP
// - Row, precharge, refresh finish inside power-down
// - Banks closed gives precharge, open gives active
// - Entry disables buffers except clock, ODT, CKE, reset
// - Receivers stay on through the CKE hold-off
// - Slow precharge power-down turns DLL off
// - Reset low leaves power-down into reset state
// - Exit power-down on CKE high with NOP
// - Long calibration runs engine, then transfers values
// - First long calibration gets the initial window
// - Short calibration corrects within its short window
`timescale 1ns/1ps
module dpz_pd_zq_ctrl #(
	parameter int ADDR_W = 14,
	parameter int IMP_W = dpz_pkg::IMP_W,
	parameter int CPDED_CYC = dpz_pkg::CPDED_CYC,
	parameter int ZQINIT_CYC = dpz_pkg::ZQINIT_CYC,
	parameter int ZQOPER_CYC = dpz_pkg::ZQOPER_CYC,
	parameter int ZQCS_CYC = dpz_pkg::ZQCS_CYC,
	parameter int ZQCS_STEP_CYC = dpz_pkg::ZQCS_STEP_CYC
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic dram_reset_b_in,
	input wire logic cke_in,
	input wire logic cs_b_in,
	input wire logic ras_b_in,
	input wire logic cas_b_in,
	input wire logic we_b_in,
	input wire logic [2:0] ba_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic bank_open_in,
	input wire logic busy_in,
	input wire logic zq_comp_hi_in,
	output dpz_pkg::dpz_pd_kind_t pd_kind_out,
	output logic in_pd_out,
	output logic dll_on_out,
	output logic io_buf_en_out,
	output logic cmd_rcv_en_out,
	output logic reset_state_out,
	output logic zq_busy_out,
	output logic zq_update_out,
	output logic zq_first_out,
	output logic [IMP_W-1:0] imp_code_out
);
	localparam int TW = dpz_pkg::TMR_W;

	dpz_pkg::dpz_pd_state_t state_q;
	dpz_pkg::dpz_pd_state_t state_d;
	dpz_pkg::dpz_pd_kind_t kind_q;
	dpz_pkg::dpz_pd_kind_t kind_d;
	logic cke_q;
	logic mr0_fast_q;
	logic zq_first_q;
	logic dll_on_q;
	logic io_buf_en_q;
	logic cmd_rcv_en_q;
	logic in_pd_q;
	logic nop_des;
	logic cmd_ok;
	logic zq_cmd;
	logic mrs_cmd;
	logic pd_entry;
	logic pd_exit;
	logic hold_expired;

	dpz_zq_if #(.IMP_W(IMP_W)) zq_bus ();

	initial begin
		if (ADDR_W <= dpz_pkg::MR0_FAST_BIT || CPDED_CYC < 1 || CPDED_CYC >= (1 << TW)) begin
			$error("dpz_pd_zq_ctrl: address width or hold-off count out of range");
		end
	end

	// Command decode; a deselect or NOP is the only legal companion of a CKE edge
	assign nop_des = cs_b_in || (ras_b_in && cas_b_in && we_b_in);
	assign cmd_ok = (state_q == dpz_pkg::ST_AWAKE) && cke_q && cke_in && dram_reset_b_in;
	assign zq_cmd = cmd_ok && !cs_b_in && ras_b_in && cas_b_in && !we_b_in;
	assign mrs_cmd = cmd_ok && !cs_b_in && !ras_b_in && !cas_b_in && !we_b_in;

	// CKE edges registered together with NOP or deselect
	assign pd_entry = (state_q == dpz_pkg::ST_AWAKE) && cke_q && !cke_in && nop_des;
	assign pd_exit = cke_in && nop_des;

	// Previous CKE sample for edge detection
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cke_q <= 1'b0;
		end else begin
			cke_q <= cke_in;
		end
	end

	// Fast-exit choice captured on a mode register set to MR0
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mr0_fast_q <= dpz_pkg::MR0_FAST_RST;
		end else if (!dram_reset_b_in) begin
			mr0_fast_q <= dpz_pkg::MR0_FAST_RST;
		end else if (mrs_cmd && ba_in == dpz_pkg::BA_MR0) begin
			mr0_fast_q <= addr_in[dpz_pkg::MR0_FAST_BIT];
		end
	end

	// Receiver hold-off after the CKE-low edge
	dpz_timer #(.W(TW)) u_hold (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.load_in(pd_entry),
		.count_in(TW'(CPDED_CYC)),
		.expired_out(hold_expired)
	);

	// Power-down sequencing; the reset pin overrides every state
	always_comb begin
		state_d = state_q;
		if (!dram_reset_b_in) begin
			state_d = dpz_pkg::ST_RESET;
		end else begin
			case (state_q)
				dpz_pkg::ST_RESET: begin
					state_d = dpz_pkg::ST_AWAKE;
				end
				dpz_pkg::ST_AWAKE: begin
					if (pd_entry) begin
						state_d = dpz_pkg::ST_CPDED;
					end
				end
				dpz_pkg::ST_CPDED: begin
					// Receivers stay live until the hold-off has run out
					if (pd_exit) begin
						state_d = dpz_pkg::ST_AWAKE;
					end else if (hold_expired) begin
						state_d = dpz_pkg::ST_PD;
					end
				end
				dpz_pkg::ST_PD: begin
					if (pd_exit) begin
						state_d = dpz_pkg::ST_AWAKE;
					end
				end
				default: begin
					state_d = dpz_pkg::ST_RESET;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= dpz_pkg::ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// Power-down kind settles once in-flight row work has finished
	always_comb begin
		kind_d = dpz_pkg::PK_NONE;
		if (state_d == dpz_pkg::ST_CPDED || state_d == dpz_pkg::ST_PD) begin
			if (kind_q == dpz_pkg::PK_ACTIVE || kind_q == dpz_pkg::PK_PRECHARGE) begin
				kind_d = kind_q;
			end else if (busy_in) begin
				kind_d = dpz_pkg::PK_PENDING;
			end else if (bank_open_in) begin
				kind_d = dpz_pkg::PK_ACTIVE;
			end else begin
				kind_d = dpz_pkg::PK_PRECHARGE;
			end
		end
	end

	// Registered status and enables, all derived from the next state
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			kind_q <= dpz_pkg::PK_NONE;
			dll_on_q <= 1'b1;
			io_buf_en_q <= 1'b0;
			cmd_rcv_en_q <= 1'b0;
			in_pd_q <= 1'b0;
		end else begin
			kind_q <= kind_d;
			// DLL off only in slow-exit precharge power-down
			dll_on_q <= !(kind_d == dpz_pkg::PK_PRECHARGE && !mr0_fast_q);
			// Data buffers off from the entry edge; clock, ODT, CKE, reset stay up
			io_buf_en_q <= (state_d == dpz_pkg::ST_AWAKE);
			// Command receivers drop only after the hold-off
			cmd_rcv_en_q <= (state_d == dpz_pkg::ST_AWAKE || state_d == dpz_pkg::ST_CPDED);
			in_pd_q <= (state_d == dpz_pkg::ST_CPDED || state_d == dpz_pkg::ST_PD);
		end
	end

	// First long calibration after any reset is owed the initial window
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			zq_first_q <= 1'b1;
		end else if (!dram_reset_b_in) begin
			zq_first_q <= 1'b1;
		end else if (zq_bus.start && zq_bus.long_sel) begin
			zq_first_q <= 1'b0;
		end
	end

	// A command arriving while calibration runs is dropped, not queued
	assign zq_bus.start = zq_cmd && !zq_bus.busy;
	assign zq_bus.long_sel = addr_in[dpz_pkg::ZQ_LONG_BIT];
	assign zq_bus.first = zq_first_q;
	assign zq_bus.abort = !dram_reset_b_in;

	dpz_zq_engine #(
		.IMP_W(IMP_W),
		.INIT_CYC(ZQINIT_CYC),
		.OPER_CYC(ZQOPER_CYC),
		.CS_CYC(ZQCS_CYC),
		.STEP_CYC(ZQCS_STEP_CYC)
	) u_zq (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.zq(zq_bus.engine),
		.comp_hi_in(zq_comp_hi_in)
	);

	// Outputs
	assign pd_kind_out = kind_q;
	assign in_pd_out = in_pd_q;
	assign dll_on_out = dll_on_q;
	assign io_buf_en_out = io_buf_en_q;
	assign cmd_rcv_en_out = cmd_rcv_en_q;
	assign reset_state_out = (state_q == dpz_pkg::ST_RESET);
	assign zq_busy_out = zq_bus.busy;
	assign zq_update_out = zq_bus.done;
	assign zq_first_out = zq_first_q;
	assign imp_code_out = zq_bus.code;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);

	// Entry edge followed by CKE staying low with reset released
	sequence s_entry;
		pd_entry && dram_reset_b_in;
	endsequence
	sequence s_low_two;
		(!cke_in && dram_reset_b_in) [*2];
	endsequence

	AST_ENTRY_CAUSE: assert property (
		(state_q == dpz_pkg::ST_CPDED && $past(state_q) == dpz_pkg::ST_AWAKE)
		|-> ($past(nop_des) && !$past(cke_in) && $past(cke_q)))
		else $error("power-down entered without CKE low and NOP");
	AST_RCV_HOLDOFF: assert property (
		s_entry |=> cmd_rcv_en_out && !io_buf_en_out ##1 cmd_rcv_en_out)
		else $error("command receivers dropped before hold-off ended");
	AST_RCV_OFF: assert property (
		s_entry ##1 s_low_two |=> !cmd_rcv_en_out && in_pd_out)
		else $error("command receivers not off after hold-off");
	AST_BUF_OFF: assert property (
		in_pd_out |-> !io_buf_en_out)
		else $error("data buffers enabled during power-down");
	AST_KIND_PRE: assert property (
		(in_pd_out && pd_kind_out == dpz_pkg::PK_PENDING && !busy_in &&
		 !bank_open_in && !cke_in && dram_reset_b_in) |=> pd_kind_out == dpz_pkg::PK_PRECHARGE)
		else $error("closed banks did not give precharge power-down");
	AST_KIND_ACT: assert property (
		(in_pd_out && pd_kind_out == dpz_pkg::PK_PENDING && !busy_in &&
		 bank_open_in && !cke_in && dram_reset_b_in) |=> pd_kind_out == dpz_pkg::PK_ACTIVE)
		else $error("open bank did not give active power-down");
	AST_PENDING: assert property (
		(in_pd_out && pd_kind_out == dpz_pkg::PK_PENDING && busy_in &&
		 !cke_in && dram_reset_b_in) |=> pd_kind_out == dpz_pkg::PK_PENDING)
		else $error("power-down kind settled while row work still running");
	AST_DLL_MODE: assert property (
		dll_on_out == !(pd_kind_out == dpz_pkg::PK_PRECHARGE && !mr0_fast_q))
		else $error("DLL state does not match power-down kind and exit mode");
	AST_RESET_LEAVE: assert property (
		(in_pd_out && !dram_reset_b_in) |=> reset_state_out && !in_pd_out)
		else $error("reset pin did not pull device out of power-down");
	AST_EXIT: assert property (
		(state_q == dpz_pkg::ST_PD && cke_in && nop_des && dram_reset_b_in)
		|=> io_buf_en_out && cmd_rcv_en_out && !in_pd_out)
		else $error("power-down not left on CKE high with NOP");
endmodule

// *** src/dpz_pkg.sv ***
// Shared constants and types for the DDR3 power-down and ZQ calibration block
package dpz_pkg;

	// Device clock rate; the core clock is the memory clock CK itself
	localparam int CLK_MHZ = 250;
	localparam int CK_PER_NCK = 1;

	// Command/address receiver hold-off after CKE falls, in nCK
	localparam int T_CPDED_NCK = 1;
	localparam int CPDED_CYC = T_CPDED_NCK * CK_PER_NCK;

	// Calibration windows in nCK (plain defaults, tune per speed grade)
	localparam int T_ZQINIT_NCK = 512;
	localparam int T_ZQOPER_NCK = 256;
	localparam int T_ZQCS_NCK = 64;
	// Window in which a short calibration must make its correction
	localparam int T_ZQCS_STEP_NCK = 64;
	localparam int ZQINIT_CYC = T_ZQINIT_NCK * CK_PER_NCK;
	localparam int ZQOPER_CYC = T_ZQOPER_NCK * CK_PER_NCK;
	localparam int ZQCS_CYC = T_ZQCS_NCK * CK_PER_NCK;
	localparam int ZQCS_STEP_CYC = T_ZQCS_STEP_NCK * CK_PER_NCK;

	// Calibration counter width and impedance code layout
	localparam int ZQ_CNT_W = 16;
	localparam int IMP_W = 6;
	localparam logic [IMP_W-1:0] IMP_RST = 6'h20;

	// Address bit positions and bank code used by the command decoder
	localparam int MR0_FAST_BIT = 12;
	localparam int ZQ_LONG_BIT = 10;
	localparam logic [2:0] BA_MR0 = 3'h0;

	// Value of the fast-exit mode bit after reset
	localparam logic MR0_FAST_RST = 1'b0;

	// Timer width for the receiver hold-off
	localparam int TMR_W = 4;

	// What kind of power-down the device is in
	typedef enum logic [1:0] {
		PK_NONE,
		PK_PENDING,
		PK_ACTIVE,
		PK_PRECHARGE
	} dpz_pd_kind_t;

	// Power-down sequencer states
	typedef enum logic [1:0] {
		ST_RESET,
		ST_AWAKE,
		ST_CPDED,
		ST_PD
	} dpz_pd_state_t;

	// Calibration engine states
	typedef enum logic {
		ZS_IDLE,
		ZS_RUN
	} dpz_zq_state_t;

endpackage

// *** src/dpz_timer.sv ***
// Loadable down-counter that flags when its interval has run out
`timescale 1ns/1ps
module dpz_timer #(
	parameter int W = dpz_pkg::TMR_W
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic load_in,
	input wire logic [W-1:0] count_in,
	output logic expired_out
);
	logic [W-1:0] count_q;

	initial begin
		if (W < 1) begin
			$error("dpz_timer: width must be at least one");
		end
	end

	// Count down to zero and rest there until reloaded
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count_q <= '0;
		end else if (load_in) begin
			count_q <= count_in;
		end else if (count_q != '0) begin
			count_q <= count_q - 1'b1;
		end
	end

	// A reload in this cycle hides the old expiry
	assign expired_out = (count_q == '0) && !load_in;
endmodule

// *** src/dpz_zq_engine.sv ***
// Impedance calibration engine for long and short calibration commands
`timescale 1ns/1ps
module dpz_zq_engine #(
	parameter int IMP_W = dpz_pkg::IMP_W,
	parameter int INIT_CYC = dpz_pkg::ZQINIT_CYC,
	parameter int OPER_CYC = dpz_pkg::ZQOPER_CYC,
	parameter int CS_CYC = dpz_pkg::ZQCS_CYC,
	parameter int STEP_CYC = dpz_pkg::ZQCS_STEP_CYC
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	dpz_zq_if.engine zq,
	input wire logic comp_hi_in
);
	localparam int CW = dpz_pkg::ZQ_CNT_W;
	localparam logic [CW-1:0] INIT_L = CW'(INIT_CYC);
	localparam logic [CW-1:0] OPER_L = CW'(OPER_CYC);
	localparam logic [CW-1:0] CS_L = CW'(CS_CYC);
	localparam logic [CW-1:0] STEP_L = CW'(STEP_CYC);
	localparam int A_INIT = INIT_CYC + 1;
	localparam int A_OPER = OPER_CYC + 1;
	localparam int A_CS = CS_CYC + 1;

	dpz_pkg::dpz_zq_state_t state_q;
	logic [CW-1:0] el_q;
	logic [CW-1:0] per_q;
	logic long_q;
	logic [IMP_W-1:0] cal_q;
	logic [IMP_W-1:0] code_q;
	logic done_q;
	logic finish;
	logic step_ok;

	initial begin
		if (INIT_CYC < 2 || INIT_CYC > 65535 || OPER_CYC < 2 || OPER_CYC > 65535 ||
		    CS_CYC < 2 || CS_CYC > 65535 || STEP_CYC < 1 || STEP_CYC > CS_CYC) begin
			$error("dpz_zq_engine: calibration periods out of range");
		end
	end

	// Last cycle of the granted window, and whether stepping is still allowed
	assign finish = (state_q == dpz_pkg::ZS_RUN) && (el_q == per_q - 1'b1);
	assign step_ok = (state_q == dpz_pkg::ZS_RUN) && (el_q < (long_q ? per_q : STEP_L));

	// Window sequencing; the first long command gets the initial window
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= dpz_pkg::ZS_IDLE;
			el_q <= '0;
			per_q <= CS_L;
			long_q <= 1'b0;
		end else if (zq.abort) begin
			state_q <= dpz_pkg::ZS_IDLE;
			el_q <= '0;
		end else begin
			case (state_q)
				dpz_pkg::ZS_IDLE: begin
					if (zq.start) begin
						state_q <= dpz_pkg::ZS_RUN;
						el_q <= '0;
						long_q <= zq.long_sel;
						per_q <= zq.long_sel ? (zq.first ? INIT_L : OPER_L) : CS_L;
					end
				end
				dpz_pkg::ZS_RUN: begin
					if (finish) begin
						state_q <= dpz_pkg::ZS_IDLE;
					end else begin
						el_q <= el_q + 1'b1;
					end
				end
				default: begin
					state_q <= dpz_pkg::ZS_IDLE;
				end
			endcase
		end
	end

	// One-count up/down stepping toward the reference comparator, saturating at both ends
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cal_q <= dpz_pkg::IMP_RST;
		end else if (zq.abort) begin
			// Aborted window drops its partial steps, so the next run starts from the drivers' code
			cal_q <= code_q;
		end else if (step_ok) begin
			// Short command only steps inside its correction window
			if (comp_hi_in && cal_q != '1) begin
				cal_q <= cal_q + 1'b1;
			end else if (!comp_hi_in && cal_q != '0) begin
				cal_q <= cal_q - 1'b1;
			end
		end
	end

	// Transfer to the I/O drivers only when the window completes
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			code_q <= dpz_pkg::IMP_RST;
			done_q <= 1'b0;
		end else begin
			done_q <= finish && !zq.abort;
			if (finish && !zq.abort) begin
				code_q <= cal_q;
			end
		end
	end

	assign zq.busy = (state_q == dpz_pkg::ZS_RUN);
	assign zq.done = done_q;
	assign zq.code = code_q;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in || zq.abort);

	AST_ZQ_INIT_LEN: assert property (
		(zq.start && !zq.busy && zq.long_sel && zq.first) |-> ##[A_INIT:A_INIT] zq.done)
		else $error("initial long calibration window wrong length");
	AST_ZQ_OPER_LEN: assert property (
		(zq.start && !zq.busy && zq.long_sel && !zq.first) |-> ##[A_OPER:A_OPER] zq.done)
		else $error("operating long calibration window wrong length");
	AST_ZQ_CS_LEN: assert property (
		(zq.start && !zq.busy && !zq.long_sel) |-> ##[A_CS:A_CS] zq.done)
		else $error("short calibration window wrong length");
	AST_ZQ_TRANSFER: assert property (
		zq.done |-> (zq.code == $past(cal_q)))
		else $error("calibrated code not transferred at completion");
	AST_ZQ_CS_FREEZE: assert property (
		(zq.busy && !long_q && el_q >= STEP_L) |=> $stable(cal_q))
		else $error("short calibration stepped outside its window");
endmodule

// *** src/dpz_zq_if.sv ***
// Signals between the power-down sequencer and the calibration engine
`timescale 1ns/1ps
interface dpz_zq_if #(
	parameter int IMP_W = dpz_pkg::IMP_W
) ();
	logic start;
	logic long_sel;
	logic first;
	logic abort;
	logic busy;
	logic done;
	logic [IMP_W-1:0] code;

	modport ctrl (
		output start,
		output long_sel,
		output first,
		output abort,
		input busy,
		input done,
		input code
	);

	modport engine (
		input start,
		input long_sel,
		input first,
		input abort,
		output busy,
		output done,
		output code
	);
endinterface

// *** verification/dpz_ctrl_model.sv ***
// Behavioural memory controller: clock enable, command pins and memory reset
`timescale 1ns/1ps
module dpz_ctrl_model #(
	parameter int T_CKE = 3,
	parameter int T_XP = 3,
	parameter int T_XPDLL = 8
) (
	input wire logic clock_in,
	input wire logic zq_busy_in,
	output logic cke_out,
	output logic [3:0] cmd_out,
	output logic [2:0] ba_out,
	output logic [13:0] addr_out,
	output logic dram_reset_b_out
);
	// Idle bus, deselected, memory out of reset
	initial begin
		cke_out = 1'b1;
		cmd_out = 4'hF;
		ba_out = 3'h0;
		addr_out = 14'h0000;
		dram_reset_b_out = 1'b1;
	end

	// One command slot, then deselect; the address is not held afterwards
	task automatic issue(input logic cke, input logic [3:0] cmd, input logic [2:0] bank,
			input logic [13:0] addr);
		@(posedge clock_in);
		cke_out <= cke;
		cmd_out <= cmd;
		ba_out <= bank;
		addr_out <= addr;
		@(posedge clock_in);
		cmd_out <= 4'hF;
		ba_out <= ~bank;
		addr_out <= ~addr;
	endtask

	// Deselect cycles; a released address bus keeps changing
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clock_in);
			addr_out <= ~addr_out;
			ba_out <= ba_out + 3'h1;
		end
	endtask

	// No self-refresh here, so the extra refresh after it never arises
	// Entry waits until calibration is over, then CKE low with NOP
	task automatic enter();
		while (zq_busy_in !== 1'b0) idle(1);
		issue(1'b0, 4'h7, ba_out, addr_out);
	endtask

	// CKE held low for the minimum pulse, kept far below the refresh limit
	task automatic leave();
		idle(T_CKE);
		issue(1'b1, 4'h7, ba_out, addr_out); // Exit with NOP
	endtask

	// Exit latency by down-counter; slow exit waits the DLL time
	task automatic settle(input logic slow);
		int n;
		n = slow ? T_XPDLL : T_XP;
		while (n > 0) begin
			idle(1);
			n--;
		end
	endtask

	// Calibration only with all banks closed, at any time after init
	task automatic zq(input logic long_cal);
		issue(1'b1, 4'h6, ba_out, {3'h0, long_cal, 10'h000});
	endtask

	// Mode register write to a chosen bank; only bank zero holds the exit mode
	task automatic mrs(input logic fast, input logic [2:0] bank);
		issue(1'b1, 4'h0, bank, {1'b0, fast, 12'h000});
	endtask

	// Memory reset pin; held high except where a test pulls it
	task automatic set_rst(input logic lvl);
		@(posedge clock_in);
		dram_reset_b_out <= lvl;
	endtask
endmodule

// *** verification/test_ddr3_power_down_zq_control.sv ***
// Self-checking bench for the power-down and calibration block
`timescale 1ns/1ps
module test_ddr3_power_down_zq_control;
	localparam int P_INIT = 8;
	localparam int P_OPER = 6;
	localparam int P_CS = 4;
	// Short steps stop before the window ends, so the freeze check has work to do
	localparam int P_STEP = 2;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic bank_open = 1'b0;
	logic busy = 1'b0;
	logic comp_hi = 1'b0;
	logic cke;
	logic [3:0] cmd;
	logic [2:0] ba;
	logic [13:0] addr;
	logic dram_rst_b;
	dpz_pkg::dpz_pd_kind_t pd_kind;
	logic in_pd, dll_on, io_buf, cmd_rcv, reset_state, zq_busy, zq_update, zq_first;
	logic [5:0] imp_code;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	int first = 1;
	integer seed = 56732;

	// Free-running memory clock
	always #2 clock_in = ~clock_in;

	dpz_ctrl_model i_ctrl (
		.clock_in(clock_in),
		.zq_busy_in(zq_busy),
		.cke_out(cke),
		.cmd_out(cmd),
		.ba_out(ba),
		.addr_out(addr),
		.dram_reset_b_out(dram_rst_b)
	);

	// Short calibration windows keep the run brief
	dpz_pd_zq_ctrl #(
		.ZQINIT_CYC(P_INIT),
		.ZQOPER_CYC(P_OPER),
		.ZQCS_CYC(P_CS),
		.ZQCS_STEP_CYC(P_STEP)
	) i_dut (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.dram_reset_b_in(dram_rst_b),
		.cke_in(cke),
		.cs_b_in(cmd[3]),
		.ras_b_in(cmd[2]),
		.cas_b_in(cmd[1]),
		.we_b_in(cmd[0]),
		.ba_in(ba),
		.addr_in(addr),
		.bank_open_in(bank_open),
		.busy_in(busy),
		.zq_comp_hi_in(comp_hi),
		.pd_kind_out(pd_kind),
		.in_pd_out(in_pd),
		.dll_on_out(dll_on),
		.io_buf_en_out(io_buf),
		.cmd_rcv_en_out(cmd_rcv),
		.reset_state_out(reset_state),
		.zq_busy_out(zq_busy),
		.zq_update_out(zq_update),
		.zq_first_out(zq_first),
		.imp_code_out(imp_code)
	);

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic done_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic wrap_up();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hang guard; the whole run needs under two hundred cycles
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			$display("[FAIL] %0t timeout", $time);
			wrap_up();
		end
	end

	// One calibration: window length, one-cycle transfer, code moved toward the comparator
	task automatic zq_run(input logic long_cal, input logic poke);
		int n;
		int p;
		int d;
		logic [5:0] old;
		p = !long_cal ? P_CS : (first != 0 ? P_INIT : P_OPER);
		old = imp_code;
		@(posedge clock_in);
		comp_hi <= 1'($random(seed));
		#1;
		chk(8'(zq_first), 8'(first), "first flag");
		i_ctrl.zq(long_cal);
		#1;
		n = 1;
		if (poke) begin
			i_ctrl.zq(1'b1);
			#1;
			n = 3;
		end
		if (long_cal) first = 0;
		while (zq_busy === 1'b1 && n < 600) begin
			@(posedge clock_in);
			#1;
			n++;
		end
		chk(8'(n), 8'(p + 1), "window");
		chk(8'(zq_update), 8'h01, "update");
		d = comp_hi ? int'(imp_code) - int'(old) : int'(old) - int'(imp_code);
		chk(8'(d > 0 && d <= (long_cal ? p : P_STEP + 1)), 8'h01, "code step");
		@(posedge clock_in);
		#1;
		chk(8'(zq_update), 8'h00, "update pulse");
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge clock_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		#1;
		chk({io_buf, cmd_rcv, dll_on, in_pd, reset_state, zq_first, zq_busy, zq_update},
			8'hE4, "awake");
		chk({2'h0, imp_code}, 8'h20, "code reset");
		done_test("reset");
		// CKE low with a real command must not enter power-down
		i_ctrl.issue(1'b0, 4'h1, 3'h0, 14'h0000);
		#1;
		chk({in_pd, io_buf}, 8'h01, "refused entry");
		// CKE stays low for its minimum pulse before rising again
		i_ctrl.idle(2);
		i_ctrl.issue(1'b1, 4'hF, 3'h0, 14'h0000);
		i_ctrl.idle(1);
		done_test("refused");
		// Slow precharge, fast precharge, then active entered while busy
		for (int i = 0; i < 3; i++) begin
			i_ctrl.mrs(i == 1, 3'h0);
			// A write to another bank must leave the exit mode alone
			i_ctrl.mrs(i != 1, 3'(($random(seed) & 6) | 1));
			i_ctrl.idle(1);
			@(posedge clock_in);
			bank_open <= (i == 2);
			busy <= (i != 1);
			i_ctrl.enter();
			#1;
			chk({in_pd, io_buf, cmd_rcv}, 8'h05, "entry");
			chk(8'(pd_kind), 8'((i != 1) ? dpz_pkg::PK_PENDING : dpz_pkg::PK_PRECHARGE),
				"kind early");
			@(posedge clock_in);
			busy <= 1'b0;
			#1;
			chk(8'(cmd_rcv), 8'h01, "rcv hold");
			@(posedge clock_in);
			#1;
			chk(8'(cmd_rcv), 8'h00, "rcv off");
			@(posedge clock_in);
			#1;
			chk(8'(pd_kind), 8'((i == 2) ? dpz_pkg::PK_ACTIVE : dpz_pkg::PK_PRECHARGE),
				"kind");
			chk(8'(dll_on), 8'(i != 0), "dll");
			i_ctrl.leave();
			#1;
			chk({in_pd, io_buf, cmd_rcv, dll_on, 2'(pd_kind)}, 8'h1C, "exit");
			i_ctrl.settle(i == 0);
			done_test("power-down kind");
		end
		// Memory reset pulled in power-down
		i_ctrl.enter();
		i_ctrl.idle(2);
		i_ctrl.set_rst(1'b0);
		@(posedge clock_in);
		#1;
		chk({reset_state, in_pd, io_buf, cmd_rcv, zq_first}, 8'h11, "reset in pd");
		i_ctrl.set_rst(1'b1);
		i_ctrl.issue(1'b1, 4'hF, 3'h0, 14'h0000);
		i_ctrl.idle(2);
		#1;
		chk({reset_state, io_buf, cmd_rcv}, 8'h03, "out of reset");
		done_test("pin reset");
		// Initial, operating and short windows; the short one also sees an ignored command
		zq_run(1'b1, 1'b0);
		zq_run(1'b1, 1'b0);
		zq_run(1'b0, 1'b1);
		// Reset mid-calibration drops the transfer and restores the initial window
		i_ctrl.zq(1'b1);
		#1;
		chk(8'(zq_busy), 8'h01, "abort start");
		i_ctrl.set_rst(1'b0);
		@(posedge clock_in);
		#1;
		chk({zq_busy, zq_update, zq_first}, 8'h01, "abort");
		i_ctrl.set_rst(1'b1);
		i_ctrl.idle(3);
		first = 1;
		zq_run(1'b1, 1'b0);
		done_test("calibration");
		wrap_up();
	end
endmodule
